// ### common/seq_engine_defines.svh
// How it works
// - bus jump command forces sequence exit
// - sequence exit when chosen input reaches level
// - sequence delay programmable 10 us to 400 ms
// - input must hold level; change restarts timer
// - monitor ORs every selected deviating input
// - monitor exit acts with no delay
// - state change refetches definition, about 20 us
// - timeout from entry exits to timeout state
// - timeout programmable 100 us to 400 ms
// - state output pattern driven and held
// - sample program: ramp timeout enters disable state
// - fault latch, one bit per input, readable
// - fault latching enabled per state
// - live status flags, never latched
// - up to 63 states, any reachable
// - three exits: sequence, monitor, timeout
// - warnings ORed, fed to sequence and monitor exits
`ifndef SEQ_ENGINE_DEFINES_SVH
`define SEQ_ENGINE_DEFINES_SVH

// sizes
`define NUM_STATES_DEF 63
`define NUM_INPUTS 10
`define EXIT_IN_W 11
`define NUM_OUTPUTS 10
`define STATE_IDX_W 6
`define SEL_W 4
`define DELAY_W 19

// timing
`define CLK_PERIOD_NS 25
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define FETCH_TIME_US 20
`define FETCH_TICKS (`FETCH_TIME_US * 1000 / `TICK_PERIOD_NS)
`define SEQ_DELAY_MIN_US 10
`define TMO_DELAY_MIN_US 100
`define DELAY_MAX_MS 400
`define SAMPLE_TMO_MS 10

// register byte addresses
`define REG_CTRL 8'h00
`define REG_STATE 8'h04
`define REG_FLAT_FIRST 8'h08
`define REG_FLAT_SECOND 8'h0C
`define REG_LIVE 8'h10
`define REG_IRQ_STAT 8'h14
`define REG_IRQ_MASK 8'h18
`define REG_DEF_IDX 8'h1C
`define REG_DEF_SEQ 8'h20
`define REG_DEF_TMO 8'h24
`define REG_DEF_MON 8'h28
`define REG_DEF_OUT 8'h2C

// field positions
`define F_DELAY_MSB 18
`define F_SEL_LSB 19
`define F_SEL_MSB 22
`define F_LEVEL_BIT 23
`define F_NEXT_LSB 24
`define F_NEXT_MSB 29
`define F_MASK_MSB 10
`define F_EXP_LSB 11
`define F_EXP_MSB 21
`define F_OUT_MSB 9
`define F_LATCH_BIT 10
`define IRQ_SEQ_BIT 0
`define IRQ_MON_BIT 1
`define IRQ_TMO_BIT 2
`define FLAT_FIRST_W 8

// sample program
`define SAMPLE_IDLE_IDX 6'h00
`define SAMPLE_ARM_IDX 6'h01
`define SAMPLE_RAMP_IDX 6'h02
`define SAMPLE_DIS_IDX 6'h03
`define SAMPLE_EN2_IDX 6'h04
`define IN_MAIN 4'h0
`define IN_RAIL1 4'h1
`define IN_START 4'h5
`define PDO_RAIL1 0
`define PDO_RAIL2 1
`define PDO_FAULT 2

`endif

// ### common/seq_engine_pkg.sv
`include "seq_engine_defines.svh"
`default_nettype none
package seq_engine_pkg;

  typedef enum logic {PH_FETCH, PH_RUN} phase_t;

  // one state definition as held in the definition store
  typedef struct packed {
    logic [`STATE_IDX_W-1:0] seq_next;
    logic [`SEL_W-1:0] seq_sel;
    logic seq_level;
    logic [`DELAY_W-1:0] seq_delay;
    logic [`STATE_IDX_W-1:0] tmo_next;
    logic [`DELAY_W-1:0] tmo_delay;
    logic [`STATE_IDX_W-1:0] mon_next;
    logic [`EXIT_IN_W-1:0] mon_mask;
    logic [`EXIT_IN_W-1:0] mon_expect;
    logic [`NUM_OUTPUTS-1:0] outputs;
    logic latch_en;
  } state_def_t;

endpackage
`default_nettype wire

// ### src/sequencing_engine.sv
// Chosen here: the address map and strobed register access.
`include "seq_engine_defines.svh"
`default_nettype none
module sequencing_engine
  import seq_engine_pkg::*;
#(
  parameter int NUM_STATES = `NUM_STATES_DEF,
  parameter int NUM_WARN = 4,
  parameter int DELAY_MAX_US = `DELAY_MAX_MS * 1000
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [31:0] rd_data_out,
  input wire logic [`NUM_INPUTS-1:0] supply_fault_detector_in,
  input wire logic [NUM_WARN-1:0] warning_in,
  input wire logic [`NUM_INPUTS-1:0] live_uv_in,
  input wire logic [`NUM_INPUTS-1:0] live_ov_in,
  input wire logic [`NUM_INPUTS-1:0] live_limit_in,
  output logic [`NUM_OUTPUTS-1:0] programmable_driver_output_out,
  output logic irq_out
);

  localparam int SYNC_W = 4 * `NUM_INPUTS + NUM_WARN;
  localparam int SEQ_MIN = `SEQ_DELAY_MIN_US;
  localparam int TMO_MIN = `TMO_DELAY_MIN_US;
  localparam logic [5:0] TICK_LAST = 6'(`TICK_CYCLES - 1);
  localparam logic [4:0] FETCH_LAST = 5'(`FETCH_TICKS - 1);
  localparam logic [`DELAY_W-1:0] CNT_MAX = '1;

  typedef struct packed {
    state_def_t [NUM_STATES-1:0] table_q;
    state_def_t act;
    logic [`STATE_IDX_W-1:0] cur;
    logic [`STATE_IDX_W-1:0] def_idx;
    phase_t phase;
    logic [5:0] tick_cnt;
    logic [`DELAY_W-1:0] seq_cnt;
    logic [`DELAY_W-1:0] tmo_cnt;
    logic [4:0] fetch_cnt;
    logic jump_pend;
    logic [`NUM_INPUTS-1:0] flatch;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [`NUM_OUTPUTS-1:0] programmable_driver_output;
    logic irq;
    logic [31:0] rdata;
  } eng_t;

  eng_t eng_reg;
  eng_t eng_next;
  logic rst_n;
  logic [SYNC_W-1:0] sync_q;
  logic [`NUM_INPUTS-1:0] sfd_s;
  logic [NUM_WARN-1:0] warn_s;
  logic [3*`NUM_INPUTS-1:0] live_vec;
  logic [`EXIT_IN_W-1:0] exit_vec;
  logic [`EXIT_IN_W-1:0] mon_dev;
  logic warn_any;
  logic run;
  logic tick;
  logic seq_match;
  logic seq_hit;
  logic tmo_hit;
  logic mon_hit;
  logic jump_hit;
  logic [`STATE_IDX_W-1:0] seq_tgt;
  logic [`STATE_IDX_W-1:0] tmo_tgt;
  logic [`STATE_IDX_W-1:0] mon_tgt;
  state_def_t sel_def;

  // clamp a programmed delay into its legal range
  function automatic logic [`DELAY_W-1:0] clamp_delay(input logic [`DELAY_W-1:0] d,
                                                     input int lo);
    if (int'(d) < lo) begin
      return `DELAY_W'(lo);
    end else if (int'(d) > DELAY_MAX_US) begin
      return `DELAY_W'(DELAY_MAX_US);
    end
    return d;
  endfunction

  // a next-state index beyond the store restarts the program at state 0
  function automatic logic [`STATE_IDX_W-1:0] clamp_idx(input logic [`STATE_IDX_W-1:0] idx);
    return (int'(idx) < NUM_STATES) ? idx : '0;
  endfunction

  // read one definition, empty when the index is outside the store
  function automatic state_def_t def_at(input eng_t e, input logic [`STATE_IDX_W-1:0] idx);
    return (int'(idx) < NUM_STATES) ? e.table_q[idx] : '0;
  endfunction

  // power-up contents: a short sample program in the first states
  function automatic eng_t reset_state();
    eng_t r;
    r = '0;
    r.phase = PH_FETCH;
    r.table_q[`SAMPLE_IDLE_IDX].seq_sel = `IN_START;
    r.table_q[`SAMPLE_IDLE_IDX].seq_next = `SAMPLE_ARM_IDX;
    r.table_q[`SAMPLE_ARM_IDX].seq_sel = `IN_MAIN;
    r.table_q[`SAMPLE_ARM_IDX].seq_level = 1'b1;
    r.table_q[`SAMPLE_ARM_IDX].seq_next = `SAMPLE_RAMP_IDX;
    r.table_q[`SAMPLE_RAMP_IDX].seq_sel = `IN_RAIL1;
    r.table_q[`SAMPLE_RAMP_IDX].seq_level = 1'b1;
    r.table_q[`SAMPLE_RAMP_IDX].seq_next = `SAMPLE_EN2_IDX;
    r.table_q[`SAMPLE_RAMP_IDX].tmo_delay = `DELAY_W'(`SAMPLE_TMO_MS * 1000);
    r.table_q[`SAMPLE_RAMP_IDX].tmo_next = `SAMPLE_DIS_IDX;
    r.table_q[`SAMPLE_RAMP_IDX].mon_mask[`IN_MAIN] = 1'b1;
    r.table_q[`SAMPLE_RAMP_IDX].mon_expect[`IN_MAIN] = 1'b1;
    r.table_q[`SAMPLE_RAMP_IDX].outputs[`PDO_RAIL1] = 1'b1;
    r.table_q[`SAMPLE_DIS_IDX].seq_sel = `IN_START;
    r.table_q[`SAMPLE_DIS_IDX].seq_level = 1'b1;
    r.table_q[`SAMPLE_DIS_IDX].outputs[`PDO_RAIL2] = 1'b1;
    r.table_q[`SAMPLE_DIS_IDX].outputs[`PDO_FAULT] = 1'b1;
    return r;
  endfunction

  // reset release and pin inputs pass two flops each
  sync_2ff #(
    .WIDTH(1)
  ) u_rst_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .clk_en_in(clk_en_in),
    .d_in(1'b1),
    .q_out(rst_n)
  );

  sync_2ff #(
    .WIDTH(SYNC_W)
  ) u_in_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .clk_en_in(clk_en_in),
    .d_in({live_limit_in, live_ov_in, live_uv_in, warning_in, supply_fault_detector_in}),
    .q_out(sync_q)
  );

  // exit conditions, all evaluated against the active definition
  assign sfd_s = sync_q[`NUM_INPUTS-1:0];
  assign warn_s = sync_q[`NUM_INPUTS +: NUM_WARN];
  assign live_vec = sync_q[SYNC_W-1 -: 3*`NUM_INPUTS];
  assign warn_any = |warn_s;
  assign exit_vec = {warn_any, sfd_s};
  assign run = eng_reg.phase == PH_RUN;
  assign tick = eng_reg.tick_cnt == TICK_LAST;
  assign seq_match = (int'(eng_reg.act.seq_sel) < `EXIT_IN_W) &&
                     (exit_vec[eng_reg.act.seq_sel] == eng_reg.act.seq_level);
  assign seq_hit = run && seq_match && ((eng_reg.act.seq_delay == '0) ||
    (eng_reg.seq_cnt >= clamp_delay(eng_reg.act.seq_delay, SEQ_MIN)));
  assign tmo_hit = run && (eng_reg.act.tmo_delay != '0) &&
    (eng_reg.tmo_cnt >= clamp_delay(eng_reg.act.tmo_delay, TMO_MIN));
  assign mon_dev = eng_reg.act.mon_mask & (exit_vec ^ eng_reg.act.mon_expect);
  assign mon_hit = run && (|mon_dev);
  assign jump_hit = run && eng_reg.jump_pend;
  assign seq_tgt = clamp_idx(eng_reg.act.seq_next);
  assign tmo_tgt = clamp_idx(eng_reg.act.tmo_next);
  assign mon_tgt = clamp_idx(eng_reg.act.mon_next);
  assign sel_def = def_at(eng_reg, eng_reg.def_idx);

  // next-state logic: engine first, then bus writes, sticky sets last so they win
  always_comb begin
    logic [2:0] ev;
    logic [`NUM_INPUTS-1:0] fset;
    eng_next = eng_reg;
    ev = 3'h0;
    fset = '0;
    eng_next.tick_cnt = tick ? 6'h00 : 6'(eng_reg.tick_cnt + 6'h01);
    if (!run) begin
      // definition fetch: the old pattern stays on the pins until it completes
      if (tick) begin
        eng_next.fetch_cnt = 5'(eng_reg.fetch_cnt + 5'h01);
      end
      if (tick && (eng_reg.fetch_cnt == FETCH_LAST)) begin
        eng_next.act = def_at(eng_reg, eng_reg.cur);
        eng_next.programmable_driver_output = eng_next.act.outputs;
        eng_next.phase = PH_RUN;
        eng_next.seq_cnt = '0;
        eng_next.tmo_cnt = '0;
      end
    end else begin
      // qualifying timer restarts whenever the input leaves its level
      if (!seq_match) begin
        eng_next.seq_cnt = '0;
      end else if (tick && (eng_reg.seq_cnt != CNT_MAX)) begin
        eng_next.seq_cnt = `DELAY_W'(eng_reg.seq_cnt + 1'b1);
      end
      if (tick && (eng_reg.tmo_cnt != CNT_MAX)) begin
        eng_next.tmo_cnt = `DELAY_W'(eng_reg.tmo_cnt + 1'b1);
      end
      if (eng_reg.act.latch_en) begin
        fset = ~sfd_s;
      end
      // exit selection, monitor first since a failing supply cannot wait
      if (mon_hit) begin
        eng_next.cur = mon_tgt;
        ev[`IRQ_MON_BIT] = 1'b1;
      end else if (seq_hit || jump_hit) begin
        eng_next.cur = seq_tgt;
        eng_next.jump_pend = 1'b0;
        ev[`IRQ_SEQ_BIT] = 1'b1;
      end else if (tmo_hit) begin
        eng_next.cur = tmo_tgt;
        ev[`IRQ_TMO_BIT] = 1'b1;
      end
      if (|ev) begin
        eng_next.phase = PH_FETCH;
        eng_next.fetch_cnt = 5'h00;
        eng_next.jump_pend = 1'b0;
      end
    end
    // register writes
    if (wr_strobe_in) begin
      case (addr_in)
        `REG_CTRL: begin
          if (wr_data_in[0]) begin
            eng_next.jump_pend = 1'b1;
          end
        end
        `REG_FLAT_FIRST: begin
          eng_next.flatch[`FLAT_FIRST_W-1:0] = eng_next.flatch[`FLAT_FIRST_W-1:0] &
                                               ~wr_data_in[`FLAT_FIRST_W-1:0];
        end
        `REG_FLAT_SECOND: begin
          eng_next.flatch[`NUM_INPUTS-1:`FLAT_FIRST_W] =
            eng_next.flatch[`NUM_INPUTS-1:`FLAT_FIRST_W] &
            ~wr_data_in[`NUM_INPUTS-`FLAT_FIRST_W-1:0];
        end
        `REG_IRQ_STAT: begin
          eng_next.irq_stat = eng_reg.irq_stat & ~wr_data_in[2:0];
        end
        `REG_IRQ_MASK: begin
          eng_next.irq_mask = wr_data_in[2:0];
        end
        `REG_DEF_IDX: begin
          eng_next.def_idx = wr_data_in[`STATE_IDX_W-1:0];
        end
        `REG_DEF_SEQ: begin
          if (int'(eng_reg.def_idx) < NUM_STATES) begin
            eng_next.table_q[eng_reg.def_idx].seq_delay = wr_data_in[`F_DELAY_MSB:0];
            eng_next.table_q[eng_reg.def_idx].seq_sel = wr_data_in[`F_SEL_MSB:`F_SEL_LSB];
            eng_next.table_q[eng_reg.def_idx].seq_level = wr_data_in[`F_LEVEL_BIT];
            eng_next.table_q[eng_reg.def_idx].seq_next = wr_data_in[`F_NEXT_MSB:`F_NEXT_LSB];
          end
        end
        `REG_DEF_TMO: begin
          if (int'(eng_reg.def_idx) < NUM_STATES) begin
            eng_next.table_q[eng_reg.def_idx].tmo_delay = wr_data_in[`F_DELAY_MSB:0];
            eng_next.table_q[eng_reg.def_idx].tmo_next = wr_data_in[`F_NEXT_MSB:`F_NEXT_LSB];
          end
        end
        `REG_DEF_MON: begin
          if (int'(eng_reg.def_idx) < NUM_STATES) begin
            eng_next.table_q[eng_reg.def_idx].mon_mask = wr_data_in[`F_MASK_MSB:0];
            eng_next.table_q[eng_reg.def_idx].mon_expect = wr_data_in[`F_EXP_MSB:`F_EXP_LSB];
            eng_next.table_q[eng_reg.def_idx].mon_next = wr_data_in[`F_NEXT_MSB:`F_NEXT_LSB];
          end
        end
        `REG_DEF_OUT: begin
          if (int'(eng_reg.def_idx) < NUM_STATES) begin
            eng_next.table_q[eng_reg.def_idx].outputs = wr_data_in[`F_OUT_MSB:0];
            eng_next.table_q[eng_reg.def_idx].latch_en = wr_data_in[`F_LATCH_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // hardware sets win over a same-cycle write-one clear
    eng_next.flatch = eng_next.flatch | fset;
    eng_next.irq_stat = eng_next.irq_stat | ev;
    eng_next.irq = |(eng_next.irq_stat & eng_next.irq_mask);
    // read data stands only in the cycle after the strobe
    eng_next.rdata = 32'h0000_0000;
    if (rd_strobe_in) begin
      case (addr_in)
        `REG_CTRL: eng_next.rdata = 32'(eng_reg.jump_pend);
        `REG_STATE: eng_next.rdata = 32'({run, 2'h0, eng_reg.cur});
        `REG_FLAT_FIRST: eng_next.rdata = 32'(eng_reg.flatch[`FLAT_FIRST_W-1:0]);
        `REG_FLAT_SECOND: eng_next.rdata = 32'(eng_reg.flatch[`NUM_INPUTS-1:`FLAT_FIRST_W]);
        `REG_LIVE: eng_next.rdata = 32'(live_vec);
        `REG_IRQ_STAT: eng_next.rdata = 32'(eng_reg.irq_stat);
        `REG_IRQ_MASK: eng_next.rdata = 32'(eng_reg.irq_mask);
        `REG_DEF_IDX: eng_next.rdata = 32'(eng_reg.def_idx);
        `REG_DEF_SEQ: begin
          eng_next.rdata = 32'({sel_def.seq_next, sel_def.seq_level, sel_def.seq_sel,
                                sel_def.seq_delay});
        end
        `REG_DEF_TMO: eng_next.rdata = 32'({sel_def.tmo_next, 5'h00, sel_def.tmo_delay});
        `REG_DEF_MON: begin
          eng_next.rdata = 32'({sel_def.mon_next, 2'h0, sel_def.mon_expect, sel_def.mon_mask});
        end
        `REG_DEF_OUT: eng_next.rdata = 32'({sel_def.latch_en, sel_def.outputs});
        default: eng_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // the whole state, frozen while the clock enable is low
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      eng_reg <= reset_state();
    end else if (clk_en_in) begin
      eng_reg <= eng_next;
    end
  end

  assign rd_data_out = eng_reg.rdata;
  assign programmable_driver_output_out = eng_reg.programmable_driver_output;
  assign irq_out = eng_reg.irq;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_fetch_start;
    run ##1 !run;
  endsequence

  sequence s_exit(logic [`STATE_IDX_W-1:0] tgt);
    !run && (eng_reg.cur == tgt);
  endsequence

  AST_MON_EXIT: assert property (
    (mon_hit && clk_en_in) |=> s_exit($past(mon_tgt)) and eng_reg.irq_stat[`IRQ_MON_BIT])
    else $error("monitor fault did not force its exit");

  AST_SEQ_EXIT: assert property (
    (seq_hit && !mon_hit && clk_en_in) |=> s_exit($past(seq_tgt)))
    else $error("sequence exit missed");

  AST_JUMP_EXIT: assert property (
    (jump_hit && !mon_hit && clk_en_in) |=> s_exit($past(seq_tgt)) and !eng_reg.jump_pend)
    else $error("jump command did not advance the engine");

  AST_TMO_EXIT: assert property (
    (tmo_hit && !seq_hit && !jump_hit && !mon_hit && clk_en_in) |=> s_exit($past(tmo_tgt)))
    else $error("timeout exit missed");

  AST_SEQ_DELAY: assert property (
    (seq_hit && (eng_reg.act.seq_delay != '0)) |-> (int'(eng_reg.seq_cnt) >= SEQ_MIN))
    else $error("sequence exit taken before its delay");

  AST_SEQ_RESTART: assert property (
    (run && !seq_match && clk_en_in) |=> (eng_reg.seq_cnt == '0))
    else $error("sequence timer not restarted on input change");

  AST_TMO_MIN: assert property (
    tmo_hit |-> (int'(eng_reg.tmo_cnt) >= TMO_MIN))
    else $error("timeout shorter than its minimum");

  AST_FETCH_HOLD: assert property (
    s_fetch_start |-> (!run && $stable(programmable_driver_output_out))[*8])
    else $error("new state took effect without a fetch delay");

  AST_PDO_HOLD: assert property (
    (run && $past(run)) |-> $stable(programmable_driver_output_out))
    else $error("outputs changed inside a state");

  AST_TIMER_ENTRY: assert property (
    $rose(run) |-> (eng_reg.seq_cnt == '0) && (eng_reg.tmo_cnt == '0))
    else $error("timers not restarted on state entry");

  AST_LATCH_SET: assert property (
    (run && eng_reg.act.latch_en && clk_en_in) |=> ((eng_reg.flatch & ~$past(sfd_s)) ==
                                                    ~$past(sfd_s)))
    else $error("input fault not latched");

  AST_LIVE_READ: assert property (
    (rd_strobe_in && (addr_in == `REG_LIVE) && clk_en_in) |=> (rd_data_out ==
                                                              32'($past(live_vec))))
    else $error("live status read wrong");

endmodule // sequencing_engine
`default_nettype wire

// ### src/sync_2ff.sv
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next.meta = d_in;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_reg <= '0;
    end else if (clk_en_in) begin
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg.stable;

endmodule // sync_2ff
`default_nettype wire

// ### testbench/rail_model.sv
`default_nettype none
module rail_model (
  input wire logic sys_clk_in,
  input wire logic rail_en_in,
  input wire logic healthy_in,
  input wire logic main_ok_in,
  input wire logic start_in,
  output logic [9:0] sfd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int ramp_cnt = 0;
  // the rail needs 50 us to ramp; a shorted rail never reports good
  always @(posedge sys_clk_in) begin
    if (!rail_en_in || !healthy_in) ramp_cnt <= 0;
    else if (ramp_cnt < 2000) ramp_cnt <= ramp_cnt + 1;
  end
  // other rails and digital inputs sit in tolerance
  assign sfd_out = {4'hF, start_in, 3'h7, (ramp_cnt == 2000), main_ok_in};
endmodule // rail_model
`default_nettype wire

// ### testbench/sequencing_engine_tb.sv
`include "seq_engine_defines.svh"
`default_nettype none
module sequencing_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, wr_s, rd_s, healthy, main_ok, start, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [9:0] programmable_driver_output, supply_fault_detector, uv, ov, lim;
  logic [3:0] warn;
  int miscompares, n_compared;

  sequencing_engine u_dut (.sys_clk_in(clk), .resetn_in(resetn), .clk_en_in(1'b1),
    .addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr_s), .rd_strobe_in(rd_s),
    .rd_data_out(rdata), .supply_fault_detector_in(supply_fault_detector), .warning_in(warn),
    .live_uv_in(uv), .live_ov_in(ov), .live_limit_in(lim),
    .programmable_driver_output_out(programmable_driver_output), .irq_out(irq));
  rail_model u_rails (.sys_clk_in(clk), .rail_en_in(programmable_driver_output[0]), .healthy_in(healthy),
    .main_ok_in(main_ok), .start_in(start), .sfd_out(supply_fault_detector));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk) wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    @(posedge clk) addr <= a;
    rd_s <= 1'b1;
    @(posedge clk) rd_s <= 1'b0;
    @(negedge clk) v = rdata;
    if (nm != "") chk(nm, e, v);
  endtask
  // poll until the engine runs in state s; bounded by n reads
  task automatic wait_state(input logic [5:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      rd(`REG_STATE, "", 0);
      if (v === {23'h0, 1'b1, 2'h0, s}) return;
    end
    chk("state", {23'h0, 1'b1, 2'h0, s}, v);
  endtask
  task automatic us(input int n);
    repeat (n * `TICK_CYCLES) @(posedge clk);
  endtask

  task automatic t_timeout;
    wr(`REG_DEF_IDX, 32'h2);
    wr(`REG_DEF_TMO, 32'h0300_00C8);
    rd(`REG_DEF_TMO, "def_tmo", 32'h0300_00C8);
    wr(`REG_DEF_IDX, 32'h4);
    wr(`REG_DEF_SEQ, 32'h00A8_0014);
    wr(`REG_DEF_OUT, 32'h0000_0400);
    wr(`REG_IRQ_MASK, 32'h7);
    wait_state(6'h00, 1000);
    @(posedge clk) healthy <= 1'b0;
    start <= 1'b0;
    wait_state(6'h02, 2000);
    chk("pdo", 32'h1, {22'h0, programmable_driver_output});
    wr(`REG_IRQ_STAT, 32'h7);
    us(150);
    rd(`REG_STATE, "state", 32'h102);
    wait_state(6'h03, 2000);
    chk("pdo", 32'h6, {22'h0, programmable_driver_output});
    rd(`REG_IRQ_STAT, "irq_stat", 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`REG_IRQ_STAT, 32'h4);
    rd(`REG_IRQ_STAT, "irq_stat", 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge clk) start <= 1'b1;
    wait_state(6'h00, 2000);
    $display("timeout test done");
  endtask

  task automatic t_seq;
    @(posedge clk) healthy <= 1'b1;
    start <= 1'b0;
    wait_state(6'h04, 3000);
    chk("pdo", 32'h0, {22'h0, programmable_driver_output});
    rd(`REG_FLAT_FIRST, "flat1", 32'h20);
    rd(`REG_FLAT_SECOND, "flat2", 32'h0);
    // a 15 us pulse is shorter than the 20 us qualifying delay
    @(posedge clk) start <= 1'b1;
    us(15);
    @(posedge clk) start <= 1'b0;
    us(10);
    rd(`REG_STATE, "state", 32'h104);
    @(posedge clk) start <= 1'b1;
    us(17);
    rd(`REG_STATE, "state", 32'h104);
    wait_state(6'h00, 1000);
    rd(`REG_IRQ_STAT, "irq_stat", 32'h1);
    wr(`REG_IRQ_STAT, 32'h7);
    wr(`REG_FLAT_FIRST, 32'hFF);
    rd(`REG_FLAT_FIRST, "flat1", 32'h0);
    $display("sequence test done");
  endtask

  task automatic t_mon;
    @(posedge clk) start <= 1'b0;
    wait_state(6'h02, 2000);
    @(posedge clk) main_ok <= 1'b0;
    start <= 1'b1;
    repeat (5) @(posedge clk);
    rd(`REG_STATE, "state", 32'h0);
    // the two sequence steps into the ramp state leave bit 0 set as well
    rd(`REG_IRQ_STAT, "irq_stat", 32'h3);
    wr(`REG_IRQ_STAT, 32'h7);
    @(posedge clk) main_ok <= 1'b1;
    wait_state(6'h00, 1000);
    $display("monitor test done");
  endtask

  task automatic t_jump;
    wr(`REG_CTRL, 32'h1);
    rd(`REG_STATE, "state", 32'h1);
    rd(`REG_IRQ_STAT, "irq_stat", 32'h1);
    $display("jump test done");
  endtask

  task automatic t_live;
    @(posedge clk) uv <= 10'h155;
    ov <= 10'h2AA;
    lim <= 10'h0F0;
    repeat (4) @(posedge clk);
    rd(`REG_LIVE, "live", {2'h0, 10'h0F0, 10'h2AA, 10'h155});
    @(posedge clk) uv <= 10'h000;
    repeat (4) @(posedge clk);
    rd(`REG_LIVE, "live", {2'h0, 10'h0F0, 10'h2AA, 10'h000});
    $display("live status test done");
  endtask

  // warning feeds the monitor; a same-cycle sequence hit must lose to it
  task automatic t_warn;
    wr(`REG_DEF_IDX, 32'h0);
    wr(`REG_DEF_MON, 32'h0300_0400);
    rd(`REG_DEF_MON, "def_mon", 32'h0300_0400);
    wait_state(6'h00, 4000);
    @(posedge clk) warn <= 4'h8;
    start <= 1'b0;
    wait_state(6'h03, 1000);
    chk("pdo", 32'h6, {22'h0, programmable_driver_output});
    $display("warning test done");
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // the whole run needs about 0.7 ms, so 2 ms only trips on a hang
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end

  initial begin
    resetn = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    healthy = 1'b1;
    main_ok = 1'b1;
    start = 1'b1;
    uv = 10'h000;
    ov = 10'h000;
    lim = 10'h000;
    warn = 4'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_timeout();
    t_seq();
    t_mon();
    t_jump();
    t_live();
    t_warn();
    print_verdict();
  end
endmodule // sequencing_engine_tb
`default_nettype wire
